/* shared/cttmr_consts.svh */
// Purpose: Register offsets, field positions and reset values of the compact timer.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Byte-wide registers sit in the low bits of each word.
`ifndef CTTMR_CONSTS_SVH
`define CTTMR_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define CTTMR_ADDR_CTRL0    12'h000
`define CTTMR_ADDR_CTRL1    12'h004
`define CTTMR_ADDR_CNT_LO   12'h008
`define CTTMR_ADDR_CNT_HI   12'h00C
`define CTTMR_ADDR_CMPA_LO  12'h010
`define CTTMR_ADDR_CMPA_HI  12'h014
`define CTTMR_ADDR_PERIOD   12'h018
`define CTTMR_ADDR_FLAGS    12'h01C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTTMR_C0_PAUSE      7
`define CTTMR_C0_ENABLE     3
`define CTTMR_C1_MODE_HI    7
`define CTTMR_C1_MODE_LO    6
`define CTTMR_C1_FUNC_HI    5
`define CTTMR_C1_FUNC_LO    4
`define CTTMR_C1_INIT       3
`define CTTMR_C1_INVERT     2
`define CTTMR_C1_SWAP       1
`define CTTMR_C1_CLRSEL     0
`define CTTMR_FL_A          0
`define CTTMR_FL_P          1

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define CTTMR_RST_BYTE      8'h00
`define CTTMR_RST_WORD      16'h0000
`define CTTMR_C0_MASK       8'hF8
`define CTTMR_CNT_MAX       16'hFFFF
`define CTTMR_CNT_ONE       16'h0001
`define CTTMR_FULL_PERIOD   17'h10000
`define CTTMR_ZERO32        32'h00000000

`endif

/* shared/cttmr_pkg.sv */
// Purpose: Types shared by the compact timer.
// Assumes: Includes no constants header; encodings are written as literal values.
// Notes:   Mode and output-function encodings.
package cttmr_pkg;

    typedef enum logic [1:0] {
        CTTMR_MODE_CMP = 2'h0,
        CTTMR_MODE_UND = 2'h1,
        CTTMR_MODE_PWM = 2'h2,
        CTTMR_MODE_TMR = 2'h3
    } cttmr_mode_t;

    typedef enum logic [1:0] {
        CTTMR_FN_00 = 2'h0,
        CTTMR_FN_01 = 2'h1,
        CTTMR_FN_10 = 2'h2,
        CTTMR_FN_11 = 2'h3
    } cttmr_func_t;

endpackage

/* logic/cttmr_top.sv */
// Purpose: Compact 16-bit timer with compare, timer and PWM modes behind APB.
// Assumes: timer_tick is a one-cycle pulse on core_clk from the clock selector.
// Notes:   Clock-source selection and pin sharing lie outside this block.
//
// What this block does
// - Read/write byte holds compare A bits 15..8, reset zero.
// - Eight-bit period value compares against counter bits 15..8 only.
// - Clear-select low: comparator P match clears the counter.
// - Period value zero lets counter wrap by overflow.
// - Mode 00 compare output, 10 PWM, 11 timer/counter.
// - Compare mode, clear-select low: raise both A and P flags.
// - Clear-select high: A match clears; only A flag raised.
// - Clear-select high, A zero: overflow at FFFF, no A flag.
// - Compare mode: pin changes only on A flag, never on P.
// - A match: 01 sets pin low, 10 high, 11 toggles; 00 no change.
// - Enable rising edge resets pin to initial level.
// - Timer mode counts and flags like compare; pin unused.
// - PWM mode ignores clear-select.
// - Swap bit chooses which value sets period and duty.
// - Duty at or above period gives 100 percent duty.
// - PWM mode raises a flag per comparator on match.
// - Initial bit sets PWM polarity; function bits; invert bit inverts.
// - PWM counting continues while output forced.
// - Each PWM period clear starts a new period.
// - PWM function 00 inactive, 01 active, 10 waveform, 11 undefined.
// - Enable rise clears counter; enable low holds value.
// - Pause high holds counter; low resumes from held value.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps

`include "cttmr_consts.svh"

module cttmr_top
    import cttmr_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        timer_tick,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             timer_out,
    output logic             timer_out_en,
    output logic             match_a_flag,
    output logic             match_p_flag
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]  ctrl0_q;
    logic [7:0]  ctrl1_q;
    logic [7:0]  cmpa_lo_q;
    logic [7:0]  compare_a_high_byte_q;
    logic [7:0]  period_compare_byte_q;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic        enable_prev_q;
    logic        pin_q;
    logic        pin_d;
    logic        seen_a_q;
    logic        seen_p_q;
    logic        pulse_a_q;
    logic        pulse_p_q;
    logic        tick_s1_q;
    logic        tick_s2_q;
    logic        tick_s3_q;
    logic [31:0] rdata_q;
    logic        ready_q;

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    wire cttmr_mode_t mode        = cttmr_mode_t'(ctrl1_q[`CTTMR_C1_MODE_HI:`CTTMR_C1_MODE_LO]);
    wire cttmr_func_t func        = cttmr_func_t'(ctrl1_q[`CTTMR_C1_FUNC_HI:`CTTMR_C1_FUNC_LO]);
    wire              init_lvl    = ctrl1_q[`CTTMR_C1_INIT];
    wire              invert      = ctrl1_q[`CTTMR_C1_INVERT];
    wire              swap        = ctrl1_q[`CTTMR_C1_SWAP];
    wire              clr_sel     = ctrl1_q[`CTTMR_C1_CLRSEL];
    wire              enable      = ctrl0_q[`CTTMR_C0_ENABLE];
    wire              pause       = ctrl0_q[`CTTMR_C0_PAUSE];
    wire              enable_rise = enable & ~enable_prev_q;
    wire [15:0]       cmp_a_value = {compare_a_high_byte_q, cmpa_lo_q};
    wire [7:0]        cmp_p_value = period_compare_byte_q;
    wire              is_pwm      = (mode == CTTMR_MODE_PWM);
    wire              is_cmp      = (mode == CTTMR_MODE_CMP);

    // ----------------------------------------------------------------
    // Counter and comparators
    // ----------------------------------------------------------------
    wire tick_edge = tick_s2_q & ~tick_s3_q;
    wire step      = tick_edge & enable & ~pause;
    wire at_max    = (count_q == `CTTMR_CNT_MAX);
    wire [15:0] count_inc = count_q + `CTTMR_CNT_ONE;

    // Comparator P sees only the top byte; a match means the step taken in this cycle reaches it.
    wire p_hit = step & (count_inc[15:8] == cmp_p_value)
                 & (count_inc[7:0] == `CTTMR_RST_BYTE)
                 & (cmp_p_value != `CTTMR_RST_BYTE);
    wire a_hit = step & (count_inc == cmp_a_value)
                 & (cmp_a_value != `CTTMR_RST_WORD);
    wire ovf   = step & at_max;

    // In PWM mode the period comparator clears the counter, chosen by swap.
    wire clr_by_a = is_pwm ? swap : clr_sel;
    wire clear    = clr_by_a ? a_hit : p_hit;

    wire flag_a = a_hit;
    wire flag_p = p_hit & (is_pwm | ~clr_sel);

    assign count_d = enable_rise ? `CTTMR_RST_WORD :
                     (clear | ovf) ? `CTTMR_RST_WORD :
                     step ? count_inc : count_q;

    // ----------------------------------------------------------------
    // PWM duty
    // ----------------------------------------------------------------
    wire [16:0] p_period = (cmp_p_value == `CTTMR_RST_BYTE) ? `CTTMR_FULL_PERIOD
                           : {1'b0, cmp_p_value, `CTTMR_RST_BYTE};
    wire [16:0] duty_val = swap ? p_period : {1'b0, cmp_a_value};
    wire [16:0] per_val  = swap ? {1'b0, cmp_a_value} : p_period;
    wire        duty_on  = (duty_val >= per_val) |
                           ({1'b0, count_q} < duty_val);
    wire        pwm_act  = (func == CTTMR_FN_01) | ((func == CTTMR_FN_10) & duty_on);
    wire        pwm_lvl  = init_lvl ? pwm_act : ~pwm_act;

    // ----------------------------------------------------------------
    // Output pin
    // ----------------------------------------------------------------
    logic cmp_next;
    always_comb begin
        case (func)
            CTTMR_FN_00: cmp_next = pin_q;
            CTTMR_FN_01: cmp_next = 1'b0;
            CTTMR_FN_10: cmp_next = 1'b1;
            CTTMR_FN_11: cmp_next = ~pin_q;
            default:     cmp_next = pin_q;
        endcase
    end

    assign pin_d = enable_rise ? init_lvl :
                   is_pwm ? pwm_lvl :
                   (is_cmp & flag_a) ? cmp_next : pin_q;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire wr_en = psel & penable & pwrite & ready_q;
    wire rd_en = psel & ~penable & ~pwrite;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        hit = (a == b);
    endfunction

    wire sel_c0  = hit(paddr, `CTTMR_ADDR_CTRL0);
    wire sel_c1  = hit(paddr, `CTTMR_ADDR_CTRL1);
    wire sel_cl  = hit(paddr, `CTTMR_ADDR_CNT_LO);
    wire sel_ch  = hit(paddr, `CTTMR_ADDR_CNT_HI);
    wire sel_al  = hit(paddr, `CTTMR_ADDR_CMPA_LO);
    wire sel_ah  = hit(paddr, `CTTMR_ADDR_CMPA_HI);
    wire sel_rp  = hit(paddr, `CTTMR_ADDR_PERIOD);
    wire sel_fl  = hit(paddr, `CTTMR_ADDR_FLAGS);
    wire mapped  = sel_c0 | sel_c1 | sel_cl | sel_ch | sel_al | sel_ah | sel_rp | sel_fl;

    wire [7:0] flags_byte = {6'h00, seen_p_q, seen_a_q};
    wire [7:0] rd_byte = sel_c0 ? ctrl0_q :
                         sel_c1 ? ctrl1_q :
                         sel_cl ? count_q[7:0] :
                         sel_ch ? count_q[15:8] :
                         sel_al ? cmpa_lo_q :
                         sel_ah ? compare_a_high_byte_q :
                         sel_rp ? period_compare_byte_q :
                         sel_fl ? flags_byte : `CTTMR_RST_BYTE;

    // ----------------------------------------------------------------
    // Write strobes and sticky flags
    // ----------------------------------------------------------------
    wire wr_c0 = wr_en & sel_c0;
    wire wr_c1 = wr_en & sel_c1;
    wire wr_al = wr_en & sel_al;
    wire wr_ah = wr_en & sel_ah;
    wire wr_rp = wr_en & sel_rp;
    wire clr_a = wr_en & sel_fl & pwdata[`CTTMR_FL_A];
    wire clr_p = wr_en & sel_fl & pwdata[`CTTMR_FL_P];

    // Sticky view: hardware set wins over the write-one clear.
    wire seen_a_d = flag_a | (seen_a_q & ~clr_a);
    wire seen_p_d = flag_p | (seen_p_q & ~clr_p);

    // ----------------------------------------------------------------
    // Next values of the bus and pin outputs
    // ----------------------------------------------------------------
    wire        ready_d        = psel & ~penable;
    wire        pslverr_d      = psel & ~penable & ~mapped;
    wire [31:0] rdata_d        = {24'h000000, rd_byte};
    wire        timer_out_d    = pin_d ^ invert;
    wire        timer_out_en_d = is_cmp | is_pwm;

    // ----------------------------------------------------------------
    // Tick synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tick_s1_q <= 1'b0;
        end else begin
            tick_s1_q <= timer_tick;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tick_s2_q <= 1'b0;
        end else begin
            tick_s2_q <= tick_s1_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tick_s3_q <= 1'b0;
        end else begin
            tick_s3_q <= tick_s2_q;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl0_q <= `CTTMR_RST_BYTE;
        end else if (wr_c0) begin
            ctrl0_q <= pwdata[7:0] & `CTTMR_C0_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl1_q <= `CTTMR_RST_BYTE;
        end else if (wr_c1) begin
            ctrl1_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cmpa_lo_q <= `CTTMR_RST_BYTE;
        end else if (wr_al) begin
            cmpa_lo_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            compare_a_high_byte_q <= `CTTMR_RST_BYTE;
        end else if (wr_ah) begin
            compare_a_high_byte_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            period_compare_byte_q <= `CTTMR_RST_BYTE;
        end else if (wr_rp) begin
            period_compare_byte_q <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Counter, pin and flags
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_q <= `CTTMR_RST_WORD;
        end else begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            enable_prev_q <= 1'b0;
        end else begin
            enable_prev_q <= enable;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            seen_a_q <= 1'b0;
        end else begin
            seen_a_q <= seen_a_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            seen_p_q <= 1'b0;
        end else begin
            seen_p_q <= seen_p_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pulse_a_q <= 1'b0;
        end else begin
            pulse_a_q <= flag_a;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pulse_p_q <= 1'b0;
        end else begin
            pulse_p_q <= flag_p;
        end
    end

    // ----------------------------------------------------------------
    // Bus and pin outputs
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= ready_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= pslverr_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_q <= `CTTMR_ZERO32;
        end else if (rd_en) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timer_out <= 1'b0;
        end else begin
            timer_out <= timer_out_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timer_out_en <= 1'b0;
        end else begin
            timer_out_en <= timer_out_en_d;
        end
    end

    assign prdata       = rdata_q;
    assign pready       = ready_q;
    assign match_a_flag = pulse_a_q;
    assign match_p_flag = pulse_p_q;

endmodule

/* verif/cttmr_assertions.sv */
// Purpose: Port-level checks of the compact timer.
// Assumes: Sees only the ports of cttmr_top.
// Notes:   Bound into every cttmr_top instance.
`timescale 1ns/1ps
`include "cttmr_consts.svh"
module cttmr_checker (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        timer_out_en,
    input wire logic        match_a_flag,
    input wire logic        match_p_flag
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic       en_q;
    logic [3:0] off_q;
    wire        wr_done = psel && penable && pready && pwrite;
    wire        c1_wr   = wr_done && (paddr == `CTTMR_ADDR_CTRL1);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            en_q  <= 1'b0;
            off_q <= 4'h0;
        end else begin
            if (wr_done && paddr == `CTTMR_ADDR_CTRL0) begin
                en_q <= pwdata[`CTTMR_C0_ENABLE];
            end
            off_q <= en_q ? 4'h0 : off_q + {3'h0, off_q != 4'hF};
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    apb_answer_a: assert property (setup_s |=> access_s)
        else $error("no answer after setup");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    slverr_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("refused read not zero");
    flag_a_pulse_a: assert property (match_a_flag |=> !match_a_flag)
        else $error("match a flag too long");
    flag_p_pulse_a: assert property (match_p_flag |=> !match_p_flag)
        else $error("match p flag too long");
    tmr_pin_off_a: assert property (c1_wr && pwdata[7:6] == 2'h3 |-> ##[1:3] !timer_out_en)
        else $error("pin driven in timer mode");
    cmp_pin_on_a: assert property (c1_wr && pwdata[7:6] == 2'h0 |-> ##[1:3] timer_out_en)
        else $error("pin not driven in compare mode");
    stopped_quiet_a: assert property (off_q == 4'hF |-> !match_a_flag && !match_p_flag)
        else $error("flag while stopped");
endmodule
bind cttmr_top cttmr_checker i_chk (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_out_en(timer_out_en),
    .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

/* verif/testbench.sv */
// Purpose: Self-checking bench of the compact timer over APB.
// Assumes: One tick pulse every five core clocks.
// Notes:   Flag pulses are counted by a monitor.
`timescale 1ns/1ps
`include "cttmr_consts.svh"
module testbench;
    import cttmr_pkg::*;
    logic core_clk, rst_n, timer_tick, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, timer_out, timer_out_en, match_a_flag, match_p_flag;
    int error_cnt, tests_run, a_cnt, p_cnt;
    cttmr_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .timer_tick(timer_tick),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_out(timer_out),
        .timer_out_en(timer_out_en), .match_a_flag(match_a_flag),
        .match_p_flag(match_p_flag));
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        a_cnt <= a_cnt + int'(match_a_flag === 1'b1);
        p_cnt <= p_cnt + int'(match_p_flag === 1'b1);
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        int i;
        i = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20) begin
            error_cnt++;
            stop_test();
        end
        chk({31'h0, pslverr}, {31'h0, err});
        if (!w) begin
            chk(prdata, exp);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(a, 1'b0, 32'h0, x, 1'b0);
    endtask
    task automatic pin(input logic e);
        chk({31'h0, timer_out}, {31'h0, e});
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            timer_tick <= 1'b1;
            @(posedge core_clk);
            timer_tick <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
    endtask
    task automatic run(input int n, input int ea, input int ep);
        int a0;
        int p0;
        a0 = a_cnt;
        p0 = p_cnt;
        ticks(n);
        chk(32'(a_cnt - a0), 32'(ea));
        chk(32'(p_cnt - p0), 32'(ep));
    endtask
    task automatic mode(input cttmr_mode_t m, input cttmr_func_t f, input logic [3:0] b);
        wr(`CTTMR_ADDR_CTRL0, 32'h00);
        wr(`CTTMR_ADDR_CTRL1, {24'h0, m, f, b});
        wr(`CTTMR_ADDR_CTRL0, 32'h08);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {core_clk, rst_n, timer_tick, psel, penable, pwrite} = 6'h00;
        {paddr, pwdata, a_cnt, p_cnt, error_cnt, tests_run} = '0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (int k = 0; k < 8; k++) begin
            rd(12'(4 * k), 32'h0);
        end
        apb(12'h020, 1'b0, 32'h0, 32'h0, 1'b1);
        apb(12'h024, 1'b1, 32'hFF, 32'h0, 1'b1);
        wr(`CTTMR_ADDR_CMPA_HI, 32'hA5);
        rd(`CTTMR_ADDR_CMPA_HI, 32'hA5);
        wr(`CTTMR_ADDR_PERIOD, 32'h5A);
        rd(`CTTMR_ADDR_PERIOD, 32'h5A);
        wr(`CTTMR_ADDR_CMPA_HI, 32'h00);
        wr(`CTTMR_ADDR_CMPA_LO, 32'h10);
        wr(`CTTMR_ADDR_PERIOD, 32'h01);
        mode(CTTMR_MODE_CMP, CTTMR_FN_11, 4'h0);
        pin(1'b0);
        run(256, 1, 1);
        rd(`CTTMR_ADDR_CNT_HI, 32'h0);
        pin(1'b1);
        rd(`CTTMR_ADDR_FLAGS, 32'h3);
        wr(`CTTMR_ADDR_FLAGS, 32'h3);
        rd(`CTTMR_ADDR_FLAGS, 32'h0);
        wr(`CTTMR_ADDR_CTRL0, 32'h88);
        ticks(5);
        rd(`CTTMR_ADDR_CNT_LO, 32'h0);
        wr(`CTTMR_ADDR_CTRL0, 32'h08);
        ticks(3);
        rd(`CTTMR_ADDR_CNT_LO, 32'h3);
        wr(`CTTMR_ADDR_CTRL0, 32'h00);
        ticks(2);
        rd(`CTTMR_ADDR_CNT_LO, 32'h3);
        mode(CTTMR_MODE_CMP, CTTMR_FN_01, 4'h8);
        rd(`CTTMR_ADDR_CNT_LO, 32'h0);
        pin(1'b1);
        run(20, 1, 0);
        pin(1'b0);
        mode(CTTMR_MODE_TMR, CTTMR_FN_11, 4'h0);
        chk({31'h0, timer_out_en}, 32'h0);
        run(256, 1, 1);
        wr(`CTTMR_ADDR_CMPA_HI, 32'h01);
        wr(`CTTMR_ADDR_CMPA_LO, 32'h80);
        wr(`CTTMR_ADDR_FLAGS, 32'h3);
        mode(CTTMR_MODE_CMP, CTTMR_FN_10, 4'h1);
        run(384, 1, 0);
        rd(`CTTMR_ADDR_FLAGS, 32'h1);
        rd(`CTTMR_ADDR_CNT_LO, 32'h0);
        pin(1'b1);
        wr(`CTTMR_ADDR_CMPA_HI, 32'h00);
        wr(`CTTMR_ADDR_CMPA_LO, 32'h40);
        mode(CTTMR_MODE_PWM, CTTMR_FN_10, 4'h9);
        ticks(10);
        pin(1'b1);
        run(246, 1, 1);
        rd(`CTTMR_ADDR_CNT_LO, 32'h0);
        ticks(70);
        pin(1'b0);
        wr(`CTTMR_ADDR_CMPA_HI, 32'h02);
        mode(CTTMR_MODE_PWM, CTTMR_FN_10, 4'h8);
        ticks(250);
        pin(1'b1);
        for (int k = 0; k < 4; k++) begin
            mode(CTTMR_MODE_PWM, cttmr_func_t'(k % 2), {1'b1, k >= 2, 2'b00});
            ticks(3);
            pin(1'((k % 2) ^ (k / 2)));
            rd(`CTTMR_ADDR_CNT_LO, 32'h3);
        end
        wr(`CTTMR_ADDR_CMPA_HI, 32'h01);
        wr(`CTTMR_ADDR_CMPA_LO, 32'h80);
        mode(CTTMR_MODE_PWM, CTTMR_FN_10, 4'hA);
        ticks(300);
        pin(1'b0);
        stop_test();
    end
endmodule
